/* shared/lpc_pkg.sv */
// Shared constants and carrier types for the lamp pin control and shadow memory block
package lpc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_MHZ = 10;
  localparam int CLK_HZ = 10_000_000;
  localparam int EE_WRITE_TIME_US = 10_000;
  localparam int EE_WRITE_CYC = EE_WRITE_TIME_US * CLK_MHZ;
  localparam int DIM_INT_HZ = 100;
  localparam int DIM_INT_CYC = CLK_HZ / DIM_INT_HZ;
  localparam int BURST_STEP_CYC = 16;

  // ==========================================================
  // Memory map
  localparam int ADDR_W = 4;
  localparam int MEM_BYTES = 16;
  localparam logic [3:0] ADDR_LAMP_CUR = 4'h0;
  localparam logic [3:0] ADDR_EMI = 4'h1;
  localparam logic [3:0] ADDR_OD_CFG = 4'h2;
  localparam logic [3:0] ADDR_CTRL2 = 4'h3;
  localparam logic [3:0] ADDR_USER_BASE = 4'h8;
  localparam int USER_BYTES = 8;
  localparam logic [7:0] EE_FACTORY_VAL = 8'h00;
  localparam logic [7:0] RD_RST_VAL = 8'h00;

  // ==========================================================
  // Field positions
  localparam int SHADOW_ONLY_POS = 7;
  localparam int LC_LSB = 0;
  localparam int LC_W = 5;
  localparam int EMI_STEP_EN_POS = 0;
  localparam int EMI_STEP_UP_POS = 1;
  localparam int EMI_STEP_SIZE_LSB = 2;
  localparam int OD_EN_POS = 7;
  localparam int OD_AMT_LSB = 0;
  localparam int OD_AMT_W = 3;
  localparam int CTRL2_LAMP_OFF_POS = 0;

  // ==========================================================
  // Pin synchroniser lane positions
  localparam int PIN_STEP = 0;
  localparam int PIN_OD = 1;
  localparam int PIN_LAMP_OFF = 2;
  localparam int PIN_ADDR_U = 3;
  localparam int PIN_ADDR_L = 4;
  localparam int PIN_DIM_OSC = 5;
  localparam int PIN_N = 6;

  // Slave address upper bits, value is arbitrary
  localparam logic [4:0] I2C_ADDR_BASE = 5'h14;

  // ==========================================================
  // Carrier types
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } lpc_mem_req_t;

  typedef struct packed {
    logic [7:0] lamp_current_reg;
    logic [7:0] emi_ctrl_reg;
    logic [7:0] overdrive_cfg_reg;
    logic [7:0] control_reg_second;
  } lpc_cfg_t;

endpackage

/* src/lpc_pin_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none

module lpc_pin_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Pins and synchronised levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;

  // One two-flop chain per lane
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_lane
      always_ff @(posedge clk_sys_i)
      begin
        if (rst_i)
        begin
          meta_reg[gi] <= 1'b0;
          sync_o[gi] <= 1'b0;
        end
        else
        begin
          meta_reg[gi] <= async_i[gi];
          sync_o[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

/* src/lpc_shadow_mem.sv */
// SRAM-shadowed nonvolatile configuration and user memory
`timescale 1ns/10ps
`default_nettype none

module lpc_shadow_mem #(
  parameter int EE_CYC = lpc_pkg::EE_WRITE_CYC
) (
  // Clock and power-up reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Access port
  input wire lpc_pkg::lpc_mem_req_t req_i,
  output logic [7:0] rd_data_o,
  output logic busy_o,
  output logic ready_o,
  // Live configuration
  output lpc_pkg::lpc_cfg_t cfg_o
);

  typedef enum {LPC_LOAD, LPC_IDLE, LPC_EE_WRITE} lpc_mem_state_t;

  lpc_mem_state_t state_reg;
  logic [7:0] sram [lpc_pkg::MEM_BYTES];
  logic [7:0] eeprom [lpc_pkg::MEM_BYTES] = '{default: lpc_pkg::EE_FACTORY_VAL};
  logic [3:0] ld_addr_reg;
  logic [31:0] ee_cnt_reg;
  logic acc;
  logic shadow_only;

  assign shadow_only = sram[lpc_pkg::ADDR_LAMP_CUR][lpc_pkg::SHADOW_ONLY_POS];
  assign acc = (state_reg == LPC_IDLE) && req_i.wr;

  // Sequencer: load after power-up, then serve writes
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state_reg <= LPC_LOAD;
      ld_addr_reg <= 4'h0;
      ee_cnt_reg <= 32'h0;
    end
    else
    begin
      case (state_reg)
        LPC_LOAD:
        begin
          ld_addr_reg <= ld_addr_reg + 4'h1;
          if (ld_addr_reg == 4'hf)
            state_reg <= LPC_IDLE;
        end
        LPC_IDLE:
        begin
          if (acc && !shadow_only)
          begin
            state_reg <= LPC_EE_WRITE;
            ee_cnt_reg <= 32'h0;
          end
        end
        LPC_EE_WRITE:
        begin
          ee_cnt_reg <= ee_cnt_reg + 32'h1;
          if (ee_cnt_reg >= EE_CYC - 1)
            state_reg <= LPC_IDLE;
        end
        default: state_reg <= LPC_IDLE;
      endcase
    end
  end

  // SRAM copy: loaded from EEPROM, shadow-only bit forced low at load
  always_ff @(posedge clk_sys_i)
  begin
    if (state_reg == LPC_LOAD)
    begin
      if (ld_addr_reg == lpc_pkg::ADDR_LAMP_CUR)
        sram[ld_addr_reg] <= {1'b0, eeprom[ld_addr_reg][6:0]};
      else
        sram[ld_addr_reg] <= eeprom[ld_addr_reg];
    end
    else if (acc)
      sram[req_i.addr] <= req_i.data;
  end

  // EEPROM commit only while shadow-only is low
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_i && acc && !shadow_only)
      eeprom[req_i.addr] <= req_i.data;
  end

  // Registered read port and status
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      rd_data_o <= lpc_pkg::RD_RST_VAL;
      busy_o <= 1'b1;
      ready_o <= 1'b0;
    end
    else
    begin
      rd_data_o <= sram[req_i.addr];
      busy_o <= (state_reg != LPC_IDLE) || (acc && !shadow_only);
      ready_o <= (state_reg != LPC_LOAD);
    end
  end

  // Live configuration reads zero until the power-up load has filled every SRAM cell
  assign cfg_o.lamp_current_reg = (state_reg == LPC_LOAD) ? 8'h00 : sram[lpc_pkg::ADDR_LAMP_CUR];
  assign cfg_o.emi_ctrl_reg = (state_reg == LPC_LOAD) ? 8'h00 : sram[lpc_pkg::ADDR_EMI];
  assign cfg_o.overdrive_cfg_reg = (state_reg == LPC_LOAD) ? 8'h00 : sram[lpc_pkg::ADDR_OD_CFG];
  assign cfg_o.control_reg_second = (state_reg == LPC_LOAD) ? 8'h00 : sram[lpc_pkg::ADDR_CTRL2];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  ee_write_busy_a: assert property (acc && !shadow_only |=> busy_o && state_reg == LPC_EE_WRITE)
    else $error("EEPROM commit did not start");
  shadow_no_ee_a: assert property (acc && shadow_only |=> state_reg == LPC_IDLE)
    else $error("Shadow-only write stalled on EEPROM");
  ee_cover_c: cover property (acc && !shadow_only);

endmodule
`default_nettype wire

/* src/lpc_lamp_pin_ctrl.sv */
// Lamp controller pin logic, gate phasing and configuration memory top
`timescale 1ns/10ps
`default_nettype none

module lpc_lamp_pin_ctrl #(
  parameter int EE_CYC = lpc_pkg::EE_WRITE_CYC,
  parameter int DIM_INT_CYC = lpc_pkg::DIM_INT_CYC
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Asynchronous control pins
  input wire logic step_in_i,
  input wire logic overdrive_in_i,
  input wire logic lamp_off_in_i,
  input wire logic addr_sel_upper_i,
  input wire logic addr_sel_lower_i,
  input wire logic dim_osc_pin_i,
  // Dimming and lamp timing settings
  input wire logic dim_ext_sel_i,
  input wire logic [6:0] burst_duty_i,
  input wire logic [7:0] half_period_i,
  input wire logic [7:0] on_time0_i,
  input wire logic [7:0] on_time1_i,
  // Fault detector events, per channel
  input wire logic [1:0] fault_det_i,
  // Memory access port
  input wire lpc_pkg::lpc_mem_req_t mem_req_i,
  output logic [7:0] mem_rd_data_o,
  output logic mem_busy_o,
  output logic mem_ready_o,
  // Frequency step and overdrive
  output logic freq_step_o,
  output logic freq_shift_up_o,
  output logic [2:0] freq_shift_pct_o,
  output logic overdrive_on_o,
  output logic [2:0] overdrive_amt_o,
  output logic [4:0] lamp_current_o,
  // Lamp power state
  output logic lamps_run_o,
  output logic power_down_o,
  output logic ctrl_reset_o,
  output logic strike_start_o,
  // Dimming and gates
  output logic dim_tick_o,
  output logic burst_dim_signal_o,
  output logic [1:0] gate_a_o,
  output logic [1:0] gate_b_o,
  // Fault pin and slave address
  output logic fault_n_o,
  output logic fault_oe_n_o,
  output logic [6:0] i2c_addr_o
);

  logic [lpc_pkg::PIN_N-1:0] pins_async;
  logic [lpc_pkg::PIN_N-1:0] pins;
  lpc_pkg::lpc_cfg_t cfg;
  logic step_req;
  logic od_req;
  logic lamp_off;
  logic lamp_off_prev_reg;
  logic lamp_off_fell;
  logic dim_prev_reg;
  logic [31:0] dim_div_reg;
  logic dim_tick_next;
  logic [10:0] burst_cnt_reg;
  logic [10:0] burst_len;
  logic [7:0] cnt_reg;
  logic phase_reg;
  logic [8:0] sum1;
  logic [7:0] cnt1;
  logic phase1;
  logic [1:0] fault_latch_reg;
  logic [1:0] fault_latch_next;

  // ==========================================================
  // Pin synchronisers
  assign pins_async = {dim_osc_pin_i, addr_sel_lower_i, addr_sel_upper_i,
                       lamp_off_in_i, overdrive_in_i, step_in_i};

  lpc_pin_sync #(.W(lpc_pkg::PIN_N)) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(pins_async),
    .sync_o(pins)
  );

  // ==========================================================
  // Configuration memory
  lpc_shadow_mem #(.EE_CYC(EE_CYC)) u_mem (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .req_i(mem_req_i),
    .rd_data_o(mem_rd_data_o),
    .busy_o(mem_busy_o),
    .ready_o(mem_ready_o),
    .cfg_o(cfg)
  );

  // ==========================================================
  // Request combining
  assign step_req = pins[lpc_pkg::PIN_STEP] | cfg.emi_ctrl_reg[lpc_pkg::EMI_STEP_EN_POS];
  assign od_req = pins[lpc_pkg::PIN_OD] | cfg.overdrive_cfg_reg[lpc_pkg::OD_EN_POS];
  assign lamp_off = pins[lpc_pkg::PIN_LAMP_OFF] | cfg.control_reg_second[lpc_pkg::CTRL2_LAMP_OFF_POS];
  assign lamp_off_fell = lamp_off_prev_reg && !lamp_off;

  // Frequency step and overdrive outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      freq_step_o <= 1'b0;
      freq_shift_up_o <= 1'b0;
      freq_shift_pct_o <= 3'h0;
      overdrive_on_o <= 1'b0;
      overdrive_amt_o <= 3'h0;
      lamp_current_o <= 5'h00;
    end
    else
    begin
      freq_step_o <= step_req;
      freq_shift_up_o <= step_req && cfg.emi_ctrl_reg[lpc_pkg::EMI_STEP_UP_POS];
      freq_shift_pct_o <= step_req ?
        {1'b0, cfg.emi_ctrl_reg[lpc_pkg::EMI_STEP_SIZE_LSB +: 2]} + 3'h1 : 3'h0;
      overdrive_on_o <= od_req;
      overdrive_amt_o <= od_req ? cfg.overdrive_cfg_reg[lpc_pkg::OD_AMT_LSB +: lpc_pkg::OD_AMT_W] : 3'h0;
      lamp_current_o <= cfg.lamp_current_reg[lpc_pkg::LC_LSB +: lpc_pkg::LC_W];
    end
  end

  // Lamp power state and controller reset on lamp-off release
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      lamp_off_prev_reg <= 1'b0;
      lamps_run_o <= 1'b0;
      power_down_o <= 1'b0;
      ctrl_reset_o <= 1'b0;
      strike_start_o <= 1'b0;
    end
    else
    begin
      lamp_off_prev_reg <= lamp_off;
      lamps_run_o <= !lamp_off;
      power_down_o <= lamp_off;
      ctrl_reset_o <= lamp_off_fell;
      strike_start_o <= lamp_off_fell;
    end
  end

  // ==========================================================
  // Fault latches: lamp-off clears, a new event beats the edge reset
  always_comb
  begin
    fault_latch_next = fault_latch_reg;
    if (lamp_off)
      fault_latch_next = 2'h0;
    else if (lamp_off_fell)
      fault_latch_next = fault_det_i;
    else
      fault_latch_next = fault_latch_reg | fault_det_i;
  end

  // Open-drain fault pin: enable low pulls the line low
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      fault_latch_reg <= 2'h0;
      fault_n_o <= 1'b0;
      fault_oe_n_o <= 1'b1;
    end
    else
    begin
      fault_latch_reg <= fault_latch_next;
      fault_n_o <= 1'b0;
      fault_oe_n_o <= !(|fault_latch_next);
    end
  end

  // Slave address from the address-select pins
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
      i2c_addr_o <= {lpc_pkg::I2C_ADDR_BASE, 2'h0};
    else
      i2c_addr_o <= {lpc_pkg::I2C_ADDR_BASE, pins[lpc_pkg::PIN_ADDR_U],
                     pins[lpc_pkg::PIN_ADDR_L]};
  end

  // ==========================================================
  // Dimming clock: external pin edge or internal divider
  assign dim_tick_next = dim_ext_sel_i ? (pins[lpc_pkg::PIN_DIM_OSC] && !dim_prev_reg)
                                       : (dim_div_reg >= DIM_INT_CYC - 1);

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      dim_prev_reg <= 1'b0;
      dim_div_reg <= 32'h0;
      dim_tick_o <= 1'b0;
    end
    else
    begin
      dim_prev_reg <= pins[lpc_pkg::PIN_DIM_OSC];
      dim_div_reg <= (dim_div_reg >= DIM_INT_CYC - 1) ? 32'h0 : dim_div_reg + 32'h1;
      dim_tick_o <= dim_tick_next;
    end
  end

  // Burst signal shared by both channels, restarted on each dimming tick
  assign burst_len = {burst_duty_i, 4'h0};

  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      burst_cnt_reg <= 11'h7ff;
      burst_dim_signal_o <= 1'b0;
    end
    else
    begin
      if (dim_tick_next)
        burst_cnt_reg <= 11'h000;
      else if (burst_cnt_reg != 11'h7ff)
        burst_cnt_reg <= burst_cnt_reg + 11'h001;
      if (burst_duty_i == 7'h7f)
        burst_dim_signal_o <= lamps_run_o;
      else
        burst_dim_signal_o <= lamps_run_o && (burst_cnt_reg < ((burst_duty_i == 7'h00) ? 11'h010 : burst_len));
    end
  end

  // ==========================================================
  // Lamp-frequency half-cycle counter for channel 0
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !burst_dim_signal_o)
    begin
      cnt_reg <= 8'h00;
      phase_reg <= 1'b0;
    end
    else if (cnt_reg >= half_period_i - 8'h01)
    begin
      cnt_reg <= 8'h00;
      phase_reg <= !phase_reg;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end

  // Channel 1 runs a quarter cycle ahead
  always_comb
  begin
    sum1 = {1'b0, cnt_reg} + {2'b00, half_period_i[7:1]};
    if (sum1 >= {1'b0, half_period_i})
    begin
      cnt1 = 8'(sum1 - {1'b0, half_period_i});
      phase1 = !phase_reg;
    end
    else
    begin
      cnt1 = sum1[7:0];
      phase1 = phase_reg;
    end
  end

  // Gate drives: one gate per half cycle, pulse width from on-time
  always_ff @(posedge clk_sys_i)
  begin
    if (rst_i || !burst_dim_signal_o)
    begin
      gate_a_o <= 2'h0;
      gate_b_o <= 2'h0;
    end
    else
    begin
      gate_a_o[0] <= !phase_reg && (cnt_reg < on_time0_i);
      gate_b_o[0] <= phase_reg && (cnt_reg < on_time0_i);
      gate_a_o[1] <= !phase1 && (cnt1 < on_time1_i);
      gate_b_o[1] <= phase1 && (cnt1 < on_time1_i);
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  step_combine_a: assert property (##1 freq_step_o == $past(step_req))
    else $error("Step output does not follow combined request");
  step_size_a: assert property (freq_step_o |-> freq_shift_pct_o >= 3'h1 && freq_shift_pct_o <= 3'h4)
    else $error("Step size out of range");
  step_idle_a: assert property (!freq_step_o |-> freq_shift_pct_o == 3'h0 && !freq_shift_up_o)
    else $error("Frequency shifted without request");
  od_combine_a: assert property (pins[lpc_pkg::PIN_OD] |=> overdrive_on_o)
    else $error("Overdrive pin ignored");
  od_nominal_a: assert property (!overdrive_on_o |-> overdrive_amt_o == 3'h0)
    else $error("Overdrive amount while not requested");
  lamp_off_a: assert property (lamp_off |=> power_down_o && !lamps_run_o && fault_oe_n_o)
    else $error("Lamp-off did not power down and clear faults");
  lamp_off_pin_a: assert property (pins[lpc_pkg::PIN_LAMP_OFF] |=> power_down_o)
    else $error("Lamp-off pin ignored");
  release_reset_a: assert property ($fell(lamp_off) |=> ctrl_reset_o && strike_start_o ##1 !ctrl_reset_o)
    else $error("Controller reset pulse wrong on lamp-off release");
  gate_excl_a: assert property ((gate_a_o & gate_b_o) == 2'h0)
    else $error("Both gates of a channel on");
  gate_burst_a: assert property (!burst_dim_signal_o |=> gate_a_o == 2'h0 && gate_b_o == 2'h0)
    else $error("Gates driven outside the burst");
  addr_pins_a: assert property (##1 i2c_addr_o[1:0] ==
    {$past(pins[lpc_pkg::PIN_ADDR_U]), $past(pins[lpc_pkg::PIN_ADDR_L])})
    else $error("Slave address does not follow select pins");
  fault_pin_a: assert property (fault_det_i != 2'h0 && !lamp_off && !lamp_off_fell |=> !fault_oe_n_o)
    else $error("Fault not signalled");

  restart_c: cover property ($fell(lamp_off) ##1 ctrl_reset_o);
  overdrive_c: cover property (overdrive_on_o && overdrive_amt_o != 3'h0);
  phased_c: cover property (gate_a_o[0] && gate_b_o[1]);
  ext_dim_c: cover property (dim_ext_sel_i && dim_tick_o);

endmodule
`default_nettype wire

/* verif/lpc_host_model.sv */
// Host model that reaches the configuration and user bytes through the memory port
`timescale 1ns/10ps
`default_nettype none

module lpc_host_model (
  // Clock
  input wire logic clk_sys_i,
  // Device answers
  input wire logic busy_i,
  input wire logic [7:0] rd_data_i,
  // Requests to the device
  output lpc_pkg::lpc_mem_req_t req_o
);
  // ==========================================================
  // Idle request at time zero
  initial req_o = '0;

  // ==========================================================
  // Byte write; returns busy as registered on the edge that takes the write
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic b);
    @(posedge clk_sys_i);
    #1;
    req_o = '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_sys_i);
    #1;
    req_o.wr = 1'b0;
    b = busy_i;
  endtask

  // Byte read; data is registered one edge after the address
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    req_o = '{wr: 1'b0, addr: a, data: 8'h00};
    @(posedge clk_sys_i);
    #1;
    d = rd_data_i;
  endtask

  // Waits out an EEPROM commit before the next write, bounded
  task automatic idle(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      @(posedge clk_sys_i);
      #1;
      ok = !busy_i;
    end
  endtask
endmodule
`default_nettype wire

/* verif/lpc_lamp_pin_ctrl_tb.sv */
// Self-checking testbench for the lamp pin control and shadow memory top
`timescale 1ns/10ps
`default_nettype none

module lpc_lamp_pin_ctrl_tb;
  // ==========================================================
  // Stimulus and observed signals
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic step_in_i = 1'b0;
  logic overdrive_in_i = 1'b0;
  logic lamp_off_in_i = 1'b0;
  logic addr_sel_upper_i = 1'b1;
  logic addr_sel_lower_i = 1'b0;
  logic [6:0] burst_duty_i = 7'h7f;
  logic dim_osc_pin_i = 1'b0;
  logic dim_ext_sel_i = 1'b0;
  logic [1:0] fault_det_i = 2'h0;
  lpc_pkg::lpc_mem_req_t mem_req;
  logic [7:0] rd_data, d;
  logic busy, ready, b, ok, seen_gate;
  logic f_step, f_up, od_on, run, lamp_off_in, crst, strk, tick, burst, flt_n, flt_oe_n;
  logic [2:0] pct, od_amt;
  logic [4:0] lamp_cur;
  logic [1:0] ga, gb;
  logic [6:0] i2c_addr;
  int fails = 0;
  int n_tests = 0;
  int n1, n2;

  // Clock and external dimming clock, 40 clock cycles a period
  always #50 clk_sys_i = ~clk_sys_i;
  always #2000 dim_osc_pin_i = ~dim_osc_pin_i;

  lpc_lamp_pin_ctrl #(.EE_CYC(8), .DIM_INT_CYC(20)) lpc_lamp_pin_ctrl_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .step_in_i(step_in_i), .overdrive_in_i(overdrive_in_i),
    .lamp_off_in_i(lamp_off_in_i), .addr_sel_upper_i(addr_sel_upper_i), .addr_sel_lower_i(addr_sel_lower_i),
    .dim_osc_pin_i(dim_osc_pin_i), .dim_ext_sel_i(dim_ext_sel_i), .burst_duty_i(burst_duty_i),
    .half_period_i(8'h08), .on_time0_i(8'h03), .on_time1_i(8'h03), .fault_det_i(fault_det_i),
    .mem_req_i(mem_req), .mem_rd_data_o(rd_data), .mem_busy_o(busy), .mem_ready_o(ready),
    .freq_step_o(f_step), .freq_shift_up_o(f_up), .freq_shift_pct_o(pct), .overdrive_on_o(od_on),
    .overdrive_amt_o(od_amt), .lamp_current_o(lamp_cur), .lamps_run_o(run), .power_down_o(lamp_off_in),
    .ctrl_reset_o(crst), .strike_start_o(strk), .dim_tick_o(tick), .burst_dim_signal_o(burst),
    .gate_a_o(ga), .gate_b_o(gb), .fault_n_o(flt_n), .fault_oe_n_o(flt_oe_n), .i2c_addr_o(i2c_addr)
  );

  lpc_host_model lpc_host_model_inst (
    .clk_sys_i(clk_sys_i), .busy_i(busy), .rd_data_i(rd_data), .req_o(mem_req)
  );

  // ==========================================================
  // Compare tasks, verdict and helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask

  task automatic summarize();
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic boot();
    ok = 1'b0;
    for (int i = 0; i < 40 && !ok; i++)
    begin
      step(1);
      ok = (ready === 1'b1);
    end
    chk1("ready", 1'b1, ok);
  endtask

  // Gates of one channel are never on together; note any activity on the A gates (ga)
  always @(posedge clk_sys_i)
  begin
    if (!rst_i && (ga & gb) !== 2'b00)
      chk("gate_overlap", 8'h00, {6'h00, ga & gb});
    if (ga !== 2'b00)
      seen_gate = 1'b1;
  end

  // Watchdog
  initial
  begin
    #2000000;
    fails++;
    summarize();
  end

  // ==========================================================
  // Test sequence
  initial
  begin
    seen_gate = 1'b0;
    step(5);
    rst_i = 1'b0;
    boot();
    chk("i2c_addr", {1'b0, lpc_pkg::I2C_ADDR_BASE, 2'b10}, {1'b0, i2c_addr});
    addr_sel_upper_i = 1'b0;
    addr_sel_lower_i = 1'b1;
    step(4);
    chk("i2c_addr_swap", {1'b0, lpc_pkg::I2C_ADDR_BASE, 2'b01}, {1'b0, i2c_addr});
    lpc_host_model_inst.rd(4'h0, d);
    chk("lamp_cur_reg", 8'h00, d);
    // User bytes commit to EEPROM while shadow-only is low
    lpc_host_model_inst.wr(4'h8, 8'ha5, b);
    chk1("busy_ee", 1'b1, b);
    lpc_host_model_inst.idle(ok);
    chk1("ee_done", 1'b1, ok);
    lpc_host_model_inst.wr(4'hf, 8'h3c, b);
    lpc_host_model_inst.idle(ok);
    lpc_host_model_inst.rd(4'h8, d);
    chk("user8", 8'ha5, d);
    lpc_host_model_inst.rd(4'hf, d);
    chk("userf", 8'h3c, d);
    // Shadow-only set: back-to-back writes with no busy time
    lpc_host_model_inst.wr(4'h0, 8'h83, b);
    lpc_host_model_inst.idle(ok);
    lpc_host_model_inst.wr(4'h8, 8'h11, b);
    chk1("busy_sram", 1'b0, b);
    lpc_host_model_inst.wr(4'h9, 8'h22, b);
    chk1("busy_sram2", 1'b0, b);
    lpc_host_model_inst.rd(4'h9, d);
    chk("user9", 8'h22, d);
    chk("lamp_cur", 8'h03, {3'h0, lamp_cur});
    // Every step size from the register, then the smallest size from the pin
    for (int i = 0; i < 4; i++)
    begin
      lpc_host_model_inst.wr(4'h1, 8'(i * 4 + 3), b);
      step(4);
      chk1("step_reg", 1'b1, f_step);
      chk1("step_up", 1'b1, f_up);
      chk("step_pct", 8'(i + 1), {5'h00, pct});
    end
    lpc_host_model_inst.wr(4'h1, 8'h00, b);
    step(4);
    chk1("step_off", 1'b0, f_step);
    step_in_i = 1'b1;
    step(4);
    chk1("step_pin", 1'b1, f_step);
    chk("step_pct_pin", 8'h01, {5'h00, pct});
    step_in_i = 1'b0;
    // Overdrive from register bit and from pin
    lpc_host_model_inst.wr(4'h2, 8'h85, b);
    step(4);
    chk("od_reg", 8'h0d, {4'h0, od_on, od_amt});
    lpc_host_model_inst.wr(4'h2, 8'h05, b);
    step(4);
    chk("od_off", 8'h00, {4'h0, od_on, od_amt});
    overdrive_in_i = 1'b1;
    step(4);
    chk("od_pin", 8'h0d, {4'h0, od_on, od_amt});
    overdrive_in_i = 1'b0;
    // Fault latch, cleared by lamp-off from the register
    fault_det_i = 2'h1;
    step(1);
    fault_det_i = 2'h0;
    step(2);
    chk("fault_pin", 8'h00, {6'h00, flt_n, flt_oe_n});
    lpc_host_model_inst.wr(4'h3, 8'h01, b);
    step(4);
    chk("lamp_off_reg", 8'h03, {5'h00, run, lamp_off_in, flt_oe_n});
    lpc_host_model_inst.wr(4'h3, 8'h00, b);
    step(4);
    // Lamp-off from the pin; its release gives one reset and one strike
    lamp_off_in_i = 1'b1;
    step(5);
    chk("lamp_off_pin", 8'h01, {6'h00, run, lamp_off_in});
    lamp_off_in_i = 1'b0;
    n1 = 0;
    n2 = 0;
    repeat (8)
    begin
      step(1);
      n1 += int'(crst === 1'b1);
      n2 += int'(strk === 1'b1);
    end
    chk("ctrl_reset", 8'h01, 8'(n1));
    chk("strike", 8'h01, 8'(n2));
    chk("lamps_run", 8'h03, {6'h00, run, burst});
    chk1("gates_seen", 1'b1, seen_gate);
    // Internal divider gives one tick per 20 cycles
    n1 = 0;
    repeat (200)
    begin
      step(1);
      n1 += int'(tick === 1'b1);
    end
    chk("int_ticks", 8'h0a, 8'(n1));
    // External dimming clock times the ticks; a one-unit burst is 16 cycles of each 40
    dim_ext_sel_i = 1'b1;
    burst_duty_i = 7'h01;
    step(40);
    n1 = 0;
    n2 = 0;
    repeat (200)
    begin
      step(1);
      n1 += int'(tick === 1'b1);
      n2 += int'(burst === 1'b1);
    end
    chk1("ext_ticks", 1'b1, n1 >= 4 && n1 <= 6);
    chk("burst_len", 8'h50, 8'(n2));
    // Power-up reload keeps only values written with shadow-only low
    rst_i = 1'b1;
    step(2);
    rst_i = 1'b0;
    boot();
    lpc_host_model_inst.rd(4'h8, d);
    chk("reload8", 8'ha5, d);
    lpc_host_model_inst.rd(4'h9, d);
    chk("reload9", lpc_pkg::EE_FACTORY_VAL, d);
    lpc_host_model_inst.rd(4'h0, d);
    chk("reload0", 8'h03, d);
    summarize();
  end
endmodule
`default_nettype wire
